// [rtl/stepseq_params.svh]
`ifndef STEPSEQ_PARAMS_SVH
`define STEPSEQ_PARAMS_SVH
// Overview of operation
// - Only rising pulse edges move the sequencer
// - Pulse and direction synchronised to system clock
// - 1024-entry sine table spans four full steps
// - Direction low adds, high subtracts step width
// - Step width doubles from 1 to 256
// - Coarser resolution snaps position to nearest valid
// - Full step visits 128, 384, 640, 896
// - Half/quarter step entered from finer start at 64/32, no zero
// - Each pulse after the first interpolated at 256x from interval
// - Previous period split into equal sub-intervals
// - Interval reaching 2^20 clocks means standstill
// - Standstill sets flag, requests standby if selected
// - Next accepted rising edge clears standstill flag
// - New rate one period later, leftovers dropped
// - Index once per period at zero point
// - Position counts modulo 1024 both directions

`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_IRQ_STATUS 8'h08
`define ADDR_IRQ_CLEAR 8'h0c
`define ADDR_IRQ_ENABLE 8'h10

`define CTRL_W 6
`define CTRL_RESET 6'h00
`define MRES_MAX 4'h8
`define IRQ_W 2

`define STATUS_POS_LSB 0
`define STATUS_STST_BIT 10
`define STATUS_DIR_BIT 11
`define STATUS_STBY_BIT 12

`define POS_W 10
`define TABLE_SIZE 1024
`define QUARTER_WAVE 10'h100
`define HALF_WAVE 512
`define SINE_AMP 255
`define SINE_DEN 327680
`define CNT_W 21
`define STANDSTILL_LIMIT 1048576
`endif

// [rtl/stepseq_pkg.sv]
package stepseq_pkg;

	typedef struct packed {
		logic index_en;
		logic interp_en;
		logic [3:0] mres;
	} ctrl_t;

	typedef struct packed {
		logic index_ev;
		logic stst_ev;
	} irq_t;

	// Gray along standstill -> measure -> run
	typedef enum logic [1:0] {
		ST_STANDSTILL = 2'b00,
		ST_MEASURE = 2'b01,
		ST_RUN = 2'b11
	} seq_state_t;

endpackage

// [rtl/step_dir_microstep_sequencer.sv]
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`include "stepseq_params.svh"

module step_dir_microstep_sequencer
	import stepseq_pkg::*;
#(
	parameter int unsigned STANDSTILL_LIMIT = `STANDSTILL_LIMIT
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_step_pulse,
	input wire logic i_rotation_sense,
	input wire logic i_power_down_select_pin,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_irq,
	output logic o_index,
	output logic o_standstill,
	output logic o_standby_req,
	output logic [9:0] o_microstep_position,
	output logic signed [8:0] o_coil_a,
	output logic signed [8:0] o_coil_b
);

	localparam logic [`CNT_W-1:0] LIMIT = `CNT_W'(STANDSTILL_LIMIT);

	if (STANDSTILL_LIMIT < 2 || STANDSTILL_LIMIT >= (1 << `CNT_W)) begin : g_bad_limit
		$error("STANDSTILL_LIMIT out of range");
	end

	function automatic logic [9:0] step_width(input logic [3:0] mres);
		return 10'h001 << mres;
	endfunction

	// Grid is offset by half a width, so the nearest point is floor plus offset
	function automatic logic [9:0] snap_pos(input logic [9:0] p, input logic [3:0] mres);
		logic [9:0] w;
		w = step_width(mres);
		return (p & ~(w - 10'h001)) | (w >> 1);
	endfunction

	// Rational sine approximation, folded to constants per table entry
	function automatic logic signed [8:0] sine_val(input int a);
		int u;
		int x;
		int v;
		u = a % `HALF_WAVE;
		x = u * (`HALF_WAVE - u);
		v = (4 * x * `SINE_AMP + (`SINE_DEN - x) / 2) / (`SINE_DEN - x);
		return (a >= `HALF_WAVE) ? -9'(v) : 9'(v);
	endfunction

	logic signed [8:0] sine_rom [0:`TABLE_SIZE-1];
	for (genvar g = 0; g < `TABLE_SIZE; g++) begin : g_rom
		assign sine_rom[g] = sine_val(g);
	end

	logic step_s1_q, step_s2_q, step_s3_q;
	logic dir_s1_q, dir_s2_q;
	seq_state_t state_q, state_d;
	logic [`CNT_W-1:0] cnt_q, cnt_d;
	logic [`CNT_W-1:0] sub_period_q, sub_period_d;
	logic [`CNT_W-1:0] sub_cnt_q, sub_cnt_d;
	logic [9:0] remaining_q, remaining_d;
	logic [9:0] pos_q, pos_d;
	logic [9:0] target_q, target_d;
	logic move_down_q;
	logic stst_q, stst_d;
	ctrl_t ctrl_q, ctrl_d;
	irq_t irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
	logic wait_q;
	logic [31:0] rdata_q;
	logic irq_q, index_q, stby_q;
	logic signed [8:0] coil_a_q, coil_b_q;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			step_s1_q <= 1'b0;
			step_s2_q <= 1'b0;
			step_s3_q <= 1'b0;
			dir_s1_q <= 1'b0;
			dir_s2_q <= 1'b0;
		end else begin
			step_s1_q <= i_step_pulse;
			step_s2_q <= step_s1_q;
			step_s3_q <= step_s2_q;
			dir_s1_q <= i_rotation_sense;
			dir_s2_q <= dir_s1_q;
		end
	end

	wire pulse = step_s2_q & ~step_s3_q;

	// Bus decode; access completes on the cycle waitrequest is low
	wire bus_req = i_read | i_write;
	wire take = bus_req & ~wait_q;
	wire wr_lane0 = i_write & take & i_byteenable[0];
	wire ctrl_wr = wr_lane0 & (i_address == `ADDR_CTRL);
	wire clr_wr = wr_lane0 & (i_address == `ADDR_IRQ_CLEAR);
	wire en_wr = wr_lane0 & (i_address == `ADDR_IRQ_ENABLE);
	wire [3:0] wr_mres = (i_writedata[3:0] > `MRES_MAX) ? `MRES_MAX : i_writedata[3:0];
	wire ctrl_t wr_ctrl = '{index_en: i_writedata[5], interp_en: i_writedata[4], mres: wr_mres};

	// Only a move to coarser resolution snaps
	wire snap_now = ctrl_wr & (wr_mres > ctrl_q.mres);
	wire [9:0] snapped = snap_pos(target_q, wr_mres);

	wire [9:0] width = step_width(ctrl_q.mres);
	wire [9:0] target_step = dir_s2_q ? target_q - width : target_q + width;
	wire interp_go = pulse & ctrl_q.interp_en & (state_q != ST_STANDSTILL);
	wire [`CNT_W-1:0] sub_raw = cnt_q >> ctrl_q.mres;
	wire pending = remaining_q != 10'h000;
	wire tick = pending & (sub_cnt_q >= sub_period_q - `CNT_W'(1));
	wire limit_hit = (state_q != ST_STANDSTILL) & (cnt_q >= LIMIT);

	assign state_d = limit_hit ? ST_STANDSTILL :
		!pulse ? state_q :
		(state_q == ST_STANDSTILL) ? ST_MEASURE : ST_RUN;
	assign cnt_d = pulse ? `CNT_W'(1) : (cnt_q >= LIMIT) ? cnt_q : cnt_q + `CNT_W'(1);

	// Leftover microsteps dropped by jumping to old target
	assign pos_d = snap_now ? snapped :
		pulse ? (interp_go ? target_q : target_step) :
		tick ? (move_down_q ? pos_q - 10'h001 : pos_q + 10'h001) : pos_q;
	// Full-step grid fixed by snap offset
	assign target_d = snap_now ? snapped : pulse ? target_step : target_q;
	assign remaining_d = snap_now ? 10'h000 :
		pulse ? (interp_go ? width : 10'h000) :
		tick ? remaining_q - 10'h001 : remaining_q;
	assign sub_period_d = pulse ? ((sub_raw == '0) ? `CNT_W'(1) : sub_raw) : sub_period_q;
	assign sub_cnt_d = (pulse | snap_now | tick | ~pending) ? '0 : sub_cnt_q + `CNT_W'(1);

	// Pulse clears, a coincident limit wins
	assign stst_d = limit_hit ? 1'b1 : pulse ? 1'b0 : stst_q;

	assign ctrl_d = ctrl_wr ? wr_ctrl : ctrl_q;

	// Set wins over clear so no event is lost
	wire irq_t events = '{index_ev: ctrl_q.index_en & (pos_q == 10'h000) & ~index_q,
		stst_ev: limit_hit};
	assign irq_stat_d = (irq_stat_q & ~(clr_wr ? irq_t'(i_writedata[`IRQ_W-1:0]) : '0)) | events;
	assign irq_en_d = en_wr ? irq_t'(i_writedata[`IRQ_W-1:0]) : irq_en_q;

	wire [31:0] status_word = 32'({stby_q, dir_s2_q, stst_q, pos_q});
	wire [31:0] rdata_d = (i_address == `ADDR_CTRL) ? 32'(ctrl_q) :
		(i_address == `ADDR_STATUS) ? status_word :
		(i_address == `ADDR_IRQ_STATUS) ? 32'(irq_stat_q) :
		(i_address == `ADDR_IRQ_ENABLE) ? 32'(irq_en_q) : 32'h0000_0000;

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			state_q <= ST_STANDSTILL;
			cnt_q <= '0;
			sub_period_q <= `CNT_W'(1);
			sub_cnt_q <= '0;
			remaining_q <= 10'h000;
			move_down_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			sub_period_q <= sub_period_d;
			sub_cnt_q <= sub_cnt_d;
			remaining_q <= remaining_d;
			move_down_q <= pulse ? dir_s2_q : move_down_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			pos_q <= 10'h000;
			target_q <= 10'h000;
			stst_q <= 1'b0;
			ctrl_q <= `CTRL_RESET;
			irq_stat_q <= '0;
			irq_en_q <= '0;
		end else begin
			pos_q <= pos_d;
			target_q <= target_d;
			stst_q <= stst_d;
			ctrl_q <= ctrl_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
		end
	end

	// One wait state; read data captured while waitrequest is high
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~(wait_q & bus_req);
			rdata_q <= (wait_q & i_read) ? rdata_d : rdata_q;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			irq_q <= 1'b0;
			index_q <= 1'b0;
			stby_q <= 1'b0;
			coil_a_q <= 9'h000;
			coil_b_q <= 9'h000;
		end else begin
			irq_q <= |(irq_stat_q & irq_en_q);
			index_q <= ctrl_q.index_en & (pos_q == 10'h000);
			// Standby only if pin selects it
			stby_q <= stst_q & i_power_down_select_pin;
			coil_a_q <= sine_rom[pos_q + `QUARTER_WAVE];
			coil_b_q <= sine_rom[pos_q];
		end
	end

	assign o_readdata = rdata_q;
	assign o_waitrequest = wait_q;
	assign o_irq = irq_q;
	assign o_index = index_q;
	assign o_standstill = stst_q;
	assign o_standby_req = stby_q;
	assign o_microstep_position = pos_q;
	assign o_coil_a = coil_a_q;
	assign o_coil_b = coil_b_q;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);

	property p_fall_idle;
		($fell(step_s2_q) && !ctrl_wr) |=> $stable(target_q);
	endproperty
	a_fall_idle: assert property (p_fall_idle) else $error("falling edge moved target");

	property p_sync;
		##2 1'b1 |-> (step_s2_q == $past(i_step_pulse, 2));
	endproperty
	a_sync: assert property (p_sync) else $error("step not two-flop synced");

	property p_add;
		(pulse && !snap_now && !dir_s2_q) |=> target_q == $past(target_q) + $past(width);
	endproperty
	a_add: assert property (p_add) else $error("forward step wrong");

	property p_sub;
		(pulse && !snap_now && dir_s2_q) |=> target_q == $past(target_q) - $past(width);
	endproperty
	a_sub: assert property (p_sub) else $error("reverse step wrong");

	property p_snap_full;
		(snap_now && wr_mres == `MRES_MAX) |=> (target_q[7:0] == 8'h80) && (pos_q == target_q);
	endproperty
	a_snap_full: assert property (p_snap_full) else $error("full-step snap wrong");

	property p_interp_load;
		interp_go && !snap_now |=> (remaining_q == $past(width)) && (pos_q == $past(target_q));
	endproperty
	a_interp_load: assert property (p_interp_load) else $error("interpolation load wrong");

	property p_first_pulse;
		(pulse && state_q == ST_STANDSTILL) |=> remaining_q == 10'h000;
	endproperty
	a_first_pulse: assert property (p_first_pulse) else $error("interpolated w/o interval");

	sequence s_stst_set;
		stst_q ##1 (o_standby_req == $past(i_power_down_select_pin));
	endsequence
	property p_standstill;
		limit_hit |=> s_stst_set;
	endproperty
	a_standstill: assert property (p_standstill) else $error("standstill not flagged");

	property p_stst_clear;
		(stst_q && pulse && !limit_hit) |=> !stst_q;
	endproperty
	a_stst_clear: assert property (p_stst_clear) else $error("standstill not cleared");

	property p_index;
		(ctrl_q.index_en && pos_q == 10'h000) |=> o_index && o_coil_b == 9'sh000;
	endproperty
	a_index: assert property (p_index) else $error("index missing at zero");

	property p_wrap;
		(tick && !pulse && !snap_now && !move_down_q && pos_q == 10'h3ff) |=> pos_q == 10'h000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("position did not wrap");

	property p_dir_sync;
		##2 1'b1 |-> (dir_s2_q == $past(i_rotation_sense, 2));
	endproperty
	a_dir_sync: assert property (p_dir_sync) else $error("direction sync wrong");

	property p_table_peak;
		(pos_q == 10'h100) |=> (o_coil_b == 9'sh0ff) && (o_coil_a == 9'sh000);
	endproperty
	a_table_peak: assert property (p_table_peak) else $error("table peak wrong");

	property p_snap;
		snap_now |=> (pos_q == target_q) && (remaining_q == 10'h000);
	endproperty
	a_snap: assert property (p_snap) else $error("snap left position apart");

	property p_full_mag;
		(pos_q[7:0] == 8'h80) |=> (o_coil_a == o_coil_b) || (o_coil_a == -o_coil_b);
	endproperty
	a_full_mag: assert property (p_full_mag) else $error("full-step coils unequal");

	property p_half_grid;
		(snap_now && wr_mres == 4'h7) |=> target_q[6:0] == 7'h40;
	endproperty
	a_half_grid: assert property (p_half_grid) else $error("half grid off");

	property p_quarter_grid;
		(snap_now && wr_mres == 4'h6) |=> target_q[5:0] == 6'h20;
	endproperty
	a_quarter_grid: assert property (p_quarter_grid) else $error("quarter grid off");

	property p_tick_step;
		(tick && !pulse && !snap_now) |=> (remaining_q == $past(remaining_q) - 10'h001) &&
			(pos_q == ($past(move_down_q) ? $past(pos_q) - 10'h001 : $past(pos_q) + 10'h001));
	endproperty
	a_tick_step: assert property (p_tick_step) else $error("microstep move wrong");

	property p_tick_gap;
		(tick && !pulse && sub_period_q > `CNT_W'(1)) |=> !tick;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("microsteps too close");

	property p_limit;
		(state_q != ST_STANDSTILL && cnt_q >= LIMIT) |=>
			(state_q == ST_STANDSTILL) && o_standstill;
	endproperty
	a_limit: assert property (p_limit) else $error("limit missed");

	property p_wrap_down;
		(tick && !pulse && !snap_now && move_down_q && pos_q == 10'h000) |=> pos_q == 10'h3ff;
	endproperty
	a_wrap_down: assert property (p_wrap_down) else $error("no downward wrap");

endmodule // step_dir_microstep_sequencer

// [bench/step_source.sv]
`timescale 1ns/10ps
module step_source (
	input wire logic i_clk_sys,
	output logic o_step,
	output logic o_dir
);
	initial begin
		o_step = 1'b0;
		o_dir = 1'b0;
	end
	// bounded pulse rate
	// Six cycles high, six plus gap cycles low, direction settled three cycles ahead
	task automatic pulse(input logic dir, input int gap);
		@(posedge i_clk_sys) o_dir <= dir;
		repeat (3) @(posedge i_clk_sys);
		o_step <= 1'b1;
		repeat (6) @(posedge i_clk_sys);
		o_step <= 1'b0;
		repeat (6 + gap) @(posedge i_clk_sys);
	endtask
endmodule // step_source

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
	import stepseq_pkg::*;
	// Must exceed the slowest full-step spacing used below
	localparam int unsigned LIMIT = 6000;
	logic clk, rst, power_down_select_pin, rd, wr, wait_req, irq, idx, stst, stby, step, dir, d;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [9:0] pos, pos_m, w;
	logic signed [8:0] coil_a, coil_b;
	logic [31:0] exp_q[$];
	int mismatches, checked, n, cur;
	integer seed;

	step_source src (.i_clk_sys(clk), .o_step(step), .o_dir(dir));
	step_dir_microstep_sequencer #(.STANDSTILL_LIMIT(LIMIT)) uut (
		.i_clk_sys(clk), .i_reset(rst), .i_step_pulse(step), .i_rotation_sense(dir),
		.i_power_down_select_pin(power_down_select_pin), .i_address(addr), .i_read(rd), .i_write(wr),
		.i_writedata(wdata), .i_byteenable(4'hf), .o_readdata(rdata),
		.o_waitrequest(wait_req), .o_irq(irq), .o_index(idx), .o_standstill(stst),
		.o_standby_req(stby), .o_microstep_position(pos), .o_coil_a(coil_a),
		.o_coil_b(coil_b));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Two idle edges after each access let registered outputs settle
	task automatic bus(input logic is_rd, input logic [7:0] a, input logic [31:0] v);
		if (is_rd) exp_q.push_back(v);
		rd <= is_rd;
		wr <= !is_rd;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		while (wait_req) @(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	always @(posedge clk) begin
		if (rd && !wait_req) check(rdata, exp_q.pop_front());
	end

	task automatic set_ctrl(input logic [5:0] v);
		int m;
		m = int'(v[3:0]);
		w = 10'd1 << m;
		if (m > cur) pos_m = (pos_m & ~(w - 10'd1)) | (w >> 1);
		cur = m;
		bus(1'b0, 8'h00, {26'h0, v});
	endtask

	task automatic step_once(input logic dr, input int gap);
		src.pulse(dr, gap);
		pos_m = dr ? pos_m - w : pos_m + w;
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Full-step spacing dominates the run; this bound means a hang
	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		power_down_select_pin = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		seed = 32'h62a6;
		pos_m = 10'h0;
		w = 10'h1;
		cur = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		check(32'({coil_a, coil_b}), {14'h0, 9'h0ff, 9'h000});
		bus(1'b1, 8'h20, 32'h0);
		bus(1'b1, 8'h10, 32'h0);
		set_ctrl(6'h20);
		bus(1'b1, 8'h00, 32'h20);
		check(32'(idx), 32'h1);
		step_once(1'b1, 0);
		check(32'(pos), 32'h3ff);
		check(32'(idx), 32'h0);
		step_once(1'b0, 0);
		check(32'(idx), 32'h1);
		bus(1'b1, 8'h08, 32'h2);
		bus(1'b0, 8'h10, 32'h2);
		check(32'(irq), 32'h1);
		bus(1'b0, 8'h0c, 32'h2);
		check(32'(irq), 32'h0);
		bus(1'b1, 8'h08, 32'h0);
		for (int k = 0; k < 24; k++) begin
			set_ctrl(6'($unsigned($random(seed)) % 9));
			repeat ((20 << cur) - 20) @(posedge clk);
			d = 1'($random(seed));
			step_once(d, 0);
			check(32'(pos), 32'(pos_m));
			if (cur == 8) check(32'(coil_a == coil_b || coil_a == -coil_b), 32'h1);
			bus(1'b1, 8'h04, {19'h0, 1'b0, d, 1'b0, pos_m});
		end
		repeat (LIMIT + 10) @(posedge clk);
		check(32'({stst, stby}), 32'h2);
		power_down_select_pin <= 1'b1;
		repeat (3) @(posedge clk);
		check(32'(stby), 32'h1);
		bus(1'b1, 8'h04, {19'h0, 1'b1, d, 1'b1, pos_m});
		bus(1'b1, 8'h08, 32'h1);
		set_ctrl(6'h12);
		step_once(1'b0, 64);
		check(32'({stst, pos}), 32'(pos_m));
		step_once(1'b0, 0);
		check(32'(pos), 32'(pos_m - w));
		n = 0;
		for (int k = 0; k < 100; k++) begin
			w = pos;
			@(posedge clk);
			if (pos !== w) n++;
		end
		check(32'(n), 32'h4);
		check(32'(pos), 32'(pos_m));
		bus(1'b0, 8'h0c, 32'h1);
		bus(1'b1, 8'h08, 32'h0);
		wrap_up();
	end
endmodule // tb
